// file: pkg/wso_defines.svh
// register offsets, field positions, reset values and timing counts for the option bank
// Function
// - after any reset each option register reads its default until first written.
// - after one write an option register ignores all further writes until reset.
// - the stop-mode monitor bit keeps the low-voltage monitor running in stop mode.
// - the monitor runs in stop mode only when power and stop-mode bits are both one.
// - the monitor reset enable bit lets the monitor issue a system reset.
// - the monitor power bit powers the low-voltage monitor.
// - monitor reset asserts after nine low cycles and holds until the rising trip level.
// - short stop recovery selects 32 instead of 4096 crystal cycles for stop exit.
// - watchdog rate bit selects 2^13-2^4 or 2^18-2^4 crystal cycles of timeout.
// - the stop-permit bit lets stop run; when clear stop is an illegal opcode.
// - the watchdog disable bit turns the watchdog off.
// - the timebase clock select bit picks bus clock or crystal clock for the dividers.
// - read protection refuses monitor-mode data array access until security passes.
`ifndef WSO_DEFINES_SVH
`define WSO_DEFINES_SVH
// ==========================================================
// register map
`define WSO_OPT1_ADDR      4'h0
`define WSO_OPT2_ADDR      4'h4
`define WSO_STAT_ADDR      4'h8
// ==========================================================
// option 1 field positions
`define WSO_F_STOP_EN      0
`define WSO_F_WD_DIS       1
`define WSO_F_WD_RATE      2
`define WSO_F_SHORT_REC    3
`define WSO_F_MON_STOP     4
`define WSO_F_MON_RST      5
`define WSO_F_MON_PWR      6
// option 2 field positions
`define WSO_F_TB_CLK       0
`define WSO_F_RD_PROT      1
// ==========================================================
// reset values
`define WSO_OPT1_RESET     8'h70
`define WSO_OPT2_RESET     8'h00
// ==========================================================
// timing counts in crystal cycles
`define WSO_LV_FILTER      4'h9
`define WSO_STOP_SHORT     13'h0020
`define WSO_STOP_LONG      13'h1000
`define WSO_WD_SHORT       18'h01FF0
`define WSO_WD_LONG        18'h3FFF0
`endif

// file: pkg/wso_pkg.sv
// types shared by the option bank
package wso_pkg;
   typedef struct packed {
      logic monitor_power_enable;
      logic monitor_reset_enable;
      logic monitor_in_stop_enable;
      logic short_stop_recovery;
      logic watchdog_rate_select;
      logic watchdog_disable;
      logic stop_permit;
   } wso_opt1_type;
   typedef struct packed {
      logic monitor_read_protect;
      logic timebase_clock_select;
   } wso_opt2_type;
   typedef enum logic [2:0] {
      WSO_LV_IDLE = 3'b001,
      WSO_LV_FILT = 3'b010,
      WSO_LV_RST  = 3'b100
   } wso_lv_state_type;
endpackage

// file: src/wso_bank.sv
// write-once system option bank with axi4-lite slave and derived controls
`timescale 1ns/1ps
`include "wso_defines.svh"
module wso_bank (
   input  wire logic                  aclk,            // system clock
   input  wire logic                  aresetn,         // sync reset, low
   input  wire logic [3:0]            s_axi_awaddr,    // write address
   input  wire logic                  s_axi_awvalid,   // write address valid
   output logic                       s_axi_awready,   // write address ready
   input  wire logic [31:0]           s_axi_wdata,     // write data
   input  wire logic [3:0]            s_axi_wstrb,     // write strobes
   input  wire logic                  s_axi_wvalid,    // write data valid
   output logic                       s_axi_wready,    // write data ready
   output logic [1:0]                 s_axi_bresp,     // write response
   output logic                       s_axi_bvalid,    // write response valid
   input  wire logic                  s_axi_bready,    // write response ready
   input  wire logic [3:0]            s_axi_araddr,    // read address
   input  wire logic                  s_axi_arvalid,   // read address valid
   output logic                       s_axi_arready,   // read address ready
   output logic [31:0]                s_axi_rdata,     // read data
   output logic [1:0]                 s_axi_rresp,     // read response
   output logic                       s_axi_rvalid,    // read valid
   input  wire logic                  s_axi_rready,    // read ready
   input  wire logic                  supply_below_fall, // supply at/below falling trip
   input  wire logic                  supply_above_rise, // supply reached rising trip
   input  wire logic                  stop_request,    // cpu decoded stop instruction
   input  wire logic                  monitor_mode,    // device in monitor mode
   input  wire logic                  security_passed, // valid security code entered
   input  wire logic                  data_access_req, // monitor-mode data array access
   output wso_pkg::wso_opt1_type      opt1_out,        // option 1 controls
   output wso_pkg::wso_opt2_type      opt2_out,        // option 2 controls
   output logic                       monitor_powered, // low-voltage monitor powered
   output logic                       monitor_stop_on, // monitor kept on in stop
   output logic                       monitor_reset,   // reset from monitor
   output logic [12:0]                stop_recovery_cycles, // stop exit delay
   output logic [17:0]                watchdog_timeout, // watchdog timeout
   output logic                       watchdog_enable, // watchdog running
   output logic                       stop_illegal,    // stop taken as illegal opcode
   output logic                       stop_accept,     // stop executed
   output logic                       timebase_use_bus, // dividers on bus clock
   output logic                       data_access_deny // monitor access refused
);
   import wso_pkg::*;

   // ==========================================================
   // option state and locks
   logic [7:0]       opt1_q;
   logic [7:0]       opt2_q;
   logic             lock1_q;
   logic             lock2_q;
   logic             aw_q;
   logic             w_q;
   logic [3:0]       awaddr_q;
   logic [7:0]       wdata_q;
   logic             wstrb0_q;
   logic             do_write;
   wso_lv_state_type lv_q;
   logic [3:0]       lv_cnt_q;

   // decode a byte from the option registers
   function automatic logic [7:0] rd_mux(input logic [3:0] a, input logic [7:0] o1,
                                         input logic [7:0] o2, input logic l1,
                                         input logic l2);
      case (a)
         `WSO_OPT1_ADDR: rd_mux = o1;
         `WSO_OPT2_ADDR: rd_mux = o2;
         `WSO_STAT_ADDR: rd_mux = {6'h00, l2, l1};
         default:        rd_mux = 8'h00;
      endcase
   endfunction

   assign do_write = aw_q && w_q && !s_axi_bvalid;

   // ==========================================================
   // write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q          <= 1'b0;
         w_q           <= 1'b0;
         awaddr_q      <= 4'h0;
         wdata_q       <= 8'h00;
         wstrb0_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q      <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
         end
      end
   end

   // write response; unmapped address answers slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_q == `WSO_OPT1_ADDR || awaddr_q == `WSO_OPT2_ADDR ||
                          awaddr_q == `WSO_STAT_ADDR) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // option registers: first write locks and stores byte 0 if its strobe is set, later ones ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt1_q  <= `WSO_OPT1_RESET;
         opt2_q  <= `WSO_OPT2_RESET;
         lock1_q <= 1'b0;
         lock2_q <= 1'b0;
      end else if (do_write) begin
         if (awaddr_q == `WSO_OPT1_ADDR && !lock1_q) begin
            lock1_q <= 1'b1;
            if (wstrb0_q) begin
               opt1_q <= {1'b0, wdata_q[6:0]};
            end
         end
         if (awaddr_q == `WSO_OPT2_ADDR && !lock2_q) begin
            lock2_q <= 1'b1;
            if (wstrb0_q) begin
               opt2_q <= {6'h00, wdata_q[1:0]};
            end
         end
      end
   end

   // read channel, one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_mux(s_axi_araddr, opt1_q, opt2_q,
                                                 lock1_q, lock2_q)};
            s_axi_rresp  <= (s_axi_araddr == `WSO_OPT1_ADDR ||
                             s_axi_araddr == `WSO_OPT2_ADDR ||
                             s_axi_araddr == `WSO_STAT_ADDR) ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // low-voltage monitor reset filter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lv_q     <= WSO_LV_IDLE;
         lv_cnt_q <= 4'h0;
      end else begin
         case (lv_q)
            WSO_LV_IDLE: begin
               lv_cnt_q <= 4'h1;
               if (opt1_q[`WSO_F_MON_PWR] && opt1_q[`WSO_F_MON_RST] && supply_below_fall) begin
                  lv_q <= WSO_LV_FILT;
               end
            end
            WSO_LV_FILT: begin
               if (!supply_below_fall || !opt1_q[`WSO_F_MON_PWR] ||
                   !opt1_q[`WSO_F_MON_RST]) begin
                  lv_q <= WSO_LV_IDLE;
               end else if (lv_cnt_q == `WSO_LV_FILTER - 4'h1) begin
                  lv_q <= WSO_LV_RST;
               end else begin
                  lv_cnt_q <= lv_cnt_q + 4'h1;
               end
            end
            WSO_LV_RST: begin
               if (supply_above_rise) begin
                  lv_q <= WSO_LV_IDLE;
               end
            end
            default: lv_q <= WSO_LV_IDLE;
         endcase
      end
   end

   // ==========================================================
   // registered control outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt1_out             <= '0;
         opt2_out             <= '0;
         monitor_powered      <= 1'b0;
         monitor_stop_on      <= 1'b0;
         monitor_reset        <= 1'b0;
         stop_recovery_cycles <= `WSO_STOP_LONG;
         watchdog_timeout     <= `WSO_WD_LONG;
         watchdog_enable      <= 1'b0;
         stop_illegal         <= 1'b0;
         stop_accept          <= 1'b0;
         timebase_use_bus     <= 1'b0;
         data_access_deny     <= 1'b0;
      end else begin
         opt1_out <= opt1_q[6:0];
         opt2_out <= opt2_q[1:0];
         monitor_powered <= opt1_q[`WSO_F_MON_PWR];
         monitor_stop_on <= opt1_q[`WSO_F_MON_PWR] && opt1_q[`WSO_F_MON_STOP];
         monitor_reset <= (lv_q == WSO_LV_RST) && opt1_q[`WSO_F_MON_RST];
         stop_recovery_cycles <= opt1_q[`WSO_F_SHORT_REC] ? `WSO_STOP_SHORT
                                                       : `WSO_STOP_LONG;
         watchdog_timeout <= opt1_q[`WSO_F_WD_RATE] ? `WSO_WD_SHORT : `WSO_WD_LONG;
         watchdog_enable <= !opt1_q[`WSO_F_WD_DIS];
         stop_illegal <= stop_request && !opt1_q[`WSO_F_STOP_EN];
         stop_accept <= stop_request && opt1_q[`WSO_F_STOP_EN];
         timebase_use_bus <= opt2_q[`WSO_F_TB_CLK];
         data_access_deny <= data_access_req && monitor_mode &&
                             opt2_q[`WSO_F_RD_PROT] && !security_passed;
      end
   end

   // ==========================================================
   // checks
   sequence s_opt1_write;
      do_write && awaddr_q == `WSO_OPT1_ADDR;
   endsequence
   AST_LOCK_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn)
      lock1_q |=> $stable(opt1_q)) else $error("locked option 1 changed");
   AST_FIRST_LOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
      s_opt1_write |=> lock1_q) else $error("first write did not lock");
   AST_RESET_DEFAULT: assert property (@(posedge aclk)
      !aresetn |=> opt1_q == `WSO_OPT1_RESET && !lock1_q) else $error("bad default");
   AST_STOP_MON: assert property (@(posedge aclk) disable iff (!aresetn)
      monitor_stop_on |-> $past(opt1_q[`WSO_F_MON_PWR])) else $error("stop monitor unpowered");
   AST_LV_NINE: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lv_q == WSO_LV_RST) |-> $past(supply_below_fall, 8) && $past(supply_below_fall))
      else $error("monitor reset without nine low cycles");
   AST_LV_FILTERED: assert property (@(posedge aclk) disable iff (!aresetn)
      (lv_q == WSO_LV_IDLE) ##1 (lv_q == WSO_LV_FILT) |-> ##[6:7] lv_q != WSO_LV_RST)
      else $error("monitor reset too early");
   AST_RESET_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
      monitor_reset |-> $past(opt1_q[`WSO_F_MON_RST])) else $error("reset while disabled");
   AST_STOP_ILLEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_request && !opt1_q[`WSO_F_STOP_EN] |=> stop_illegal && !stop_accept)
      else $error("stop not illegal");
   AST_WD_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
      opt1_q[`WSO_F_WD_RATE] && $stable(opt1_q) |=> watchdog_timeout == `WSO_WD_SHORT)
      else $error("watchdog timeout wrong");
   AST_PROTECT: assert property (@(posedge aclk) disable iff (!aresetn)
      data_access_req && monitor_mode && opt2_q[`WSO_F_RD_PROT] && !security_passed
      |=> data_access_deny) else $error("access not refused");
   AST_OPT2_LOCK: assert property (@(posedge aclk) disable iff (!aresetn)
      lock2_q |=> $stable(opt2_q)) else $error("locked option 2 changed");
   AST_OPT2_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && awaddr_q == `WSO_OPT2_ADDR |=> lock2_q)
      else $error("first option 2 write did not lock");
   AST_OPT2_DEFAULT: assert property (@(posedge aclk)
      !aresetn |=> opt2_q == `WSO_OPT2_RESET && !lock2_q) else $error("bad option 2 default");
   AST_POWERED: assert property (@(posedge aclk) disable iff (!aresetn)
      aresetn |=> monitor_powered == $past(opt1_q[`WSO_F_MON_PWR]))
      else $error("monitor power mismatch");
   AST_STOP_ON: assert property (@(posedge aclk) disable iff (!aresetn)
      aresetn |=> monitor_stop_on == ($past(opt1_q[`WSO_F_MON_PWR]) &&
                                      $past(opt1_q[`WSO_F_MON_STOP])))
      else $error("stop-mode monitor mismatch");
   AST_MON_RST_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      !opt1_q[`WSO_F_MON_RST] |=> !monitor_reset)
      else $error("monitor reset not suppressed");
   AST_STOP_REC: assert property (@(posedge aclk) disable iff (!aresetn)
      aresetn |=> stop_recovery_cycles == ($past(opt1_q[`WSO_F_SHORT_REC]) ?
                                           `WSO_STOP_SHORT : `WSO_STOP_LONG))
      else $error("stop recovery mismatch");
   AST_WD_EN: assert property (@(posedge aclk) disable iff (!aresetn)
      aresetn |=> watchdog_enable == !$past(opt1_q[`WSO_F_WD_DIS]))
      else $error("watchdog enable mismatch");
   AST_STOP_ACCEPT: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_request && opt1_q[`WSO_F_STOP_EN] |=> stop_accept && !stop_illegal)
      else $error("stop not accepted");
   AST_TB_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
      aresetn |=> timebase_use_bus == $past(opt2_q[`WSO_F_TB_CLK]))
      else $error("timebase select mismatch");
   AST_DENY_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      !opt2_q[`WSO_F_RD_PROT] |=> !data_access_deny)
      else $error("access refused while unprotected");

   // ==========================================================
   // run of consecutive cycles with the supply below the falling trip
   logic [3:0]       low_run_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !supply_below_fall) begin
         low_run_q <= 4'h0;
      end else if (low_run_q != 4'hF) begin
         low_run_q <= low_run_q + 4'h1; // saturates so long runs do not wrap
      end
   end
   sequence s_lv_trip;
      $rose(lv_q == WSO_LV_RST);
   endsequence
   AST_LV_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
      s_lv_trip |-> low_run_q >= `WSO_LV_FILTER) else $error("monitor reset on a short run");
   AST_LV_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      lv_q == WSO_LV_RST && !supply_above_rise |=> lv_q == WSO_LV_RST)
      else $error("monitor reset released early");
endmodule

// file: tb/wso_bank_tb_top.sv
// self-checking testbench for the write-once option bank
`timescale 1ns/1ps
`include "wso_defines.svh"
module wso_bank_tb_top;
   import wso_pkg::*;
   // ==========================================================
   // signals
   logic                aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                s_axi_rvalid, s_axi_rready;
   logic [3:0]          s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [1:0]          s_axi_bresp, s_axi_rresp;
   logic                supply_below_fall, supply_above_rise, stop_request, monitor_mode;
   logic                security_passed, data_access_req, monitor_powered, monitor_stop_on;
   logic                monitor_reset, watchdog_enable, stop_illegal, stop_accept;
   logic                timebase_use_bus, data_access_deny;
   wso_opt1_type        opt1_out;
   wso_opt2_type        opt2_out;
   logic [12:0]         stop_recovery_cycles;
   logic [17:0]         watchdog_timeout;
   int                  n_errors, samples_checked, cyc;
   logic [31:0]         rd;
   logic [1:0]          rsp;

   wso_bank u_wso_bank (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .supply_below_fall, .supply_above_rise, .stop_request,
      .monitor_mode, .security_passed, .data_access_req, .opt1_out, .opt2_out, .monitor_powered,
      .monitor_stop_on, .monitor_reset, .stop_recovery_cycles, .watchdog_timeout, .watchdog_enable,
      .stop_illegal, .stop_accept, .timebase_use_bus, .data_access_deny);

   // ==========================================================
   // clock and hang limit
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         print_verdict();
      end
   end
   // ==========================================================
   // common tasks
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // write one register byte; address and data offered together
   task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      bit aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      axi_rd(a, rd, rsp);
      chk("rdata", {24'h000000, e}, rd);
      chk("rresp", 2'h0, rsp);
   endtask
   task automatic do_reset(input int n);
      aresetn <= 1'b0;
      repeat (n) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_lv(input logic trip);
      // eight low cycles are one short of the filter
      supply_below_fall <= 1'b1;
      repeat (8) @(posedge aclk);
      supply_below_fall <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("mon_rst_short", 1'b0, monitor_reset);
      supply_below_fall <= 1'b1;
      repeat (7) @(posedge aclk);
      chk("mon_rst_early", 1'b0, monitor_reset);
      repeat (6) @(posedge aclk);
      chk("mon_rst_trip", trip, monitor_reset);
      supply_below_fall <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("mon_rst_hold", trip, monitor_reset);
      supply_above_rise <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("mon_rst_rel", 1'b0, monitor_reset);
      supply_above_rise <= 1'b0;
   endtask
   task automatic t_stop(input logic acc);
      stop_request <= 1'b1;
      @(posedge aclk);
      stop_request <= 1'b0;
      @(posedge aclk);
      chk("stop_accept", acc, stop_accept);
      chk("stop_illegal", !acc, stop_illegal);
   endtask
   task automatic t_deny(input logic sec, input logic e);
      monitor_mode <= 1'b1;
      security_passed <= sec;
      data_access_req <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("deny", e, data_access_deny);
      data_access_req <= 1'b0;
      @(posedge aclk);
   endtask
   // derived controls for a given option-1 byte
   task automatic t_ctl(input logic [7:0] v);
      repeat (3) @(posedge aclk);
      chk("opt1_out", v[6:0], opt1_out);
      chk("powered", v[6], monitor_powered);
      chk("stop_on", v[6] & v[4], monitor_stop_on);
      chk("wd_en", !v[1], watchdog_enable);
      chk("stop_rec", v[3] ? 13'h0020 : 13'h1000, stop_recovery_cycles);
      chk("wd_to", v[2] ? 18'h01FF0 : 18'h3FFF0, watchdog_timeout);
   endtask
   task automatic t_write_once();
      axi_wr(`WSO_OPT1_ADDR, 8'h1F, rsp);
      chk("bresp", 2'h0, rsp);
      rd_chk(`WSO_OPT1_ADDR, 8'h1F);
      rd_chk(`WSO_STAT_ADDR, 8'h01);
      t_ctl(8'h1F);
      t_stop(1'b1);
      axi_wr(`WSO_OPT1_ADDR, 8'h70, rsp);
      chk("bresp", 2'h0, rsp);
      rd_chk(`WSO_OPT1_ADDR, 8'h1F);
      t_lv(1'b0);
      axi_wr(`WSO_OPT2_ADDR, 8'h03, rsp);
      axi_wr(`WSO_OPT2_ADDR, 8'h00, rsp);
      rd_chk(`WSO_OPT2_ADDR, 8'h03);
      rd_chk(`WSO_STAT_ADDR, 8'h03);
      chk("tb_bus", 1'b1, timebase_use_bus);
      chk("opt2_out", 2'h3, opt2_out);
      t_deny(1'b0, 1'b1);
      t_deny(1'b1, 1'b0);
   endtask
   task automatic t_bus();
      axi_wr(4'hC, 8'hFF, rsp);
      chk("bresp_bad", 2'h2, rsp);
      axi_rd(4'hC, rd, rsp);
      chk("rresp_bad", 2'h2, rsp);
      chk("rdata_bad", 32'h00000000, rd);
      axi_wr(`WSO_STAT_ADDR, 8'h00, rsp);
      chk("bresp_stat", 2'h0, rsp);
      rd_chk(`WSO_STAT_ADDR, 8'h03);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {supply_below_fall, supply_above_rise, stop_request, monitor_mode} = '0;
      {security_passed, data_access_req} = '0;
      n_errors = 0;
      samples_checked = 0;
      cyc = 0;
      aresetn = 1'b0;
      do_reset(16);
      rd_chk(`WSO_OPT1_ADDR, `WSO_OPT1_RESET);
      rd_chk(`WSO_OPT2_ADDR, `WSO_OPT2_RESET);
      rd_chk(`WSO_STAT_ADDR, 8'h00);
      t_ctl(`WSO_OPT1_RESET);
      chk("tb_bus", 1'b0, timebase_use_bus);
      chk("opt2_out", 2'h0, opt2_out);
      t_stop(1'b0);
      t_lv(1'b1);
      t_deny(1'b0, 1'b0);
      t_write_once();
      t_bus();
      do_reset(3);
      rd_chk(`WSO_OPT1_ADDR, `WSO_OPT1_RESET);
      rd_chk(`WSO_STAT_ADDR, 8'h00);
      axi_wr(`WSO_OPT1_ADDR, 8'h60, rsp);
      rd_chk(`WSO_OPT1_ADDR, 8'h60);
      t_ctl(8'h60);
      // a first write with byte 0 masked still locks but keeps the default
      s_axi_wstrb <= 4'h0;
      axi_wr(`WSO_OPT2_ADDR, 8'h03, rsp);
      chk("bresp_mask", 2'h0, rsp);
      rd_chk(`WSO_OPT2_ADDR, `WSO_OPT2_RESET);
      rd_chk(`WSO_STAT_ADDR, 8'h03);
      print_verdict();
   end
endmodule
